// ### core/pdp_pwm.sv
// 14-bit pulse-division pwm with a classic wishbone register slave
`timescale 1ns/1ps
`include "pdp_map.svh"

module pdp_pwm #(
	parameter int ADDR_W = `PDP_ADDR_W,
	parameter int PULSE_COUNT = `PDP_PULSES,
	parameter int UNIT_STEPS = `PDP_UNIT_STEPS,
	parameter int PERIOD_SHORT = `PDP_PERIOD_SHORT
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [ADDR_W-1:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic portLevel,
	output logic sharedPwmOutputPin
);
	localparam int PERIOD_LONG = 2 * PERIOD_SHORT;
	// named copies so single fields can be picked out of the reset values
	localparam pdp_pkg::pdp_byte_t CTRL_RESET = `PDP_CTRL_RESET;
	localparam pdp_pkg::pdp_byte_t UPPER_RESET = `PDP_UPPER_RESET;
	localparam pdp_pkg::pdp_duty_t DUTY_RESET = {UPPER_RESET[`PDP_UPPER_MSB:0], `PDP_LOWER_RESET};

	if (ADDR_W != `PDP_ADDR_W || PERIOD_SHORT != PULSE_COUNT * UNIT_STEPS) begin : g_bad
		$error("address width or period length not servable");
	end

	// bus decode
	logic reqNow;
	logic [`PDP_IDX_W-1:0] regIdx;
	logic hitCtrl;
	logic hitUpper;
	logic hitLower;
	logic hitStatus;
	logic hitMode;
	logic writeOnlyHit;
	logic laneWr;
	logic ctrlWr;
	logic upperWr;
	logic lowerWr;
	logic modeWr;
	logic ackQ;
	pdp_pkg::pdp_byte_t rdNext;
	pdp_pkg::pdp_byte_t rdData;
	pdp_pkg::pdp_byte_t statusByte;

	// control and data state
	logic selReg;
	logic selActive;
	pdp_pkg::pdp_byte_t lowerReg;
	pdp_pkg::pdp_duty_t pendingDuty;
	logic pendingValid;
	pdp_pkg::pdp_duty_t activeDuty;
	pdp_pkg::pdp_duty_t newDuty;
	logic portModeSelectOne;
	logic presc;
	logic unitTick;
	logic pwmLevel;
	logic periodEnd;
	pdp_pkg::pdp_pulse_t pulseIdx;
	logic pinQ;

	assign reqNow = wb_cyc_i && wb_stb_i;
	assign regIdx = wb_adr_i[ADDR_W-1:2];
	assign hitCtrl = regIdx == `PDP_IDX_CTRL;
	assign hitUpper = regIdx == `PDP_IDX_UPPER;
	assign hitLower = regIdx == `PDP_IDX_LOWER;
	assign hitStatus = regIdx == `PDP_IDX_STATUS;
	assign hitMode = regIdx == `PDP_IDX_PORTMODE;
	assign writeOnlyHit = hitCtrl || hitUpper || hitLower;

	// a write lands on the edge where the master sees ack, never earlier
	assign laneWr = reqNow && wb_we_i && ackQ && wb_sel_i[0];
	assign ctrlWr = laneWr && hitCtrl;
	assign upperWr = laneWr && hitUpper;
	assign lowerWr = laneWr && hitLower;
	assign modeWr = laneWr && hitMode;

	assign statusByte = {pwmLevel, pendingValid, pulseIdx};

	// write-only registers answer all ones, whatever was stored
	assign rdNext = writeOnlyHit ? `PDP_WO_READ :
		hitStatus ? statusByte :
		hitMode ? {7'h00, portModeSelectOne} :
		`PDP_ZERO_READ;

	assign wb_ack_o = ackQ;
	assign wb_dat_o = {24'h000000, rdData};

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			ackQ <= 1'b0;
			rdData <= `PDP_ZERO_READ;
		end else begin
			ackQ <= reqNow && !ackQ;
			if (reqNow && !ackQ) begin
				rdData <= rdNext;
			end
		end
	end

	// upper-byte write combines with the lower byte already held
	assign newDuty = {wb_dat_i[`PDP_UPPER_MSB:0], lowerReg};

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			selReg <= CTRL_RESET[`PDP_SEL_BIT];
			lowerReg <= `PDP_LOWER_RESET;
			portModeSelectOne <= 1'b0;
		end else begin
			if (ctrlWr) begin
				selReg <= wb_dat_i[`PDP_SEL_BIT];
			end
			if (lowerWr) begin
				lowerReg <= wb_dat_i[7:0];
			end
			if (modeWr) begin
				portModeSelectOne <= wb_dat_i[`PDP_PORTMODE_BIT];
			end
		end
	end

	// duty and clock select change only at a period boundary, so no period is torn
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pendingDuty <= DUTY_RESET;
			pendingValid <= 1'b0;
			activeDuty <= DUTY_RESET;
			selActive <= CTRL_RESET[`PDP_SEL_BIT];
		end else begin
			if (upperWr) begin
				pendingDuty <= newDuty;
			end
			// a write in the boundary cycle is taken directly, not lost, so nothing stays pending
			pendingValid <= !periodEnd && (upperWr || pendingValid);
			if (periodEnd) begin
				activeDuty <= upperWr ? newDuty : pendingDuty;
				selActive <= selReg;
			end
		end
	end

	// half-step tick: every clock at select 0, every second clock at select 1
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			presc <= 1'b0;
		end else begin
			presc <= periodEnd ? 1'b0 : !presc;
		end
	end

	assign unitTick = selActive ? presc : 1'b1;

	pdp_pulse_gen #(
		.PULSE_COUNT(PULSE_COUNT),
		.UNIT_STEPS(UNIT_STEPS)
	) u_gen (
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.unitTick(unitTick),
		.duty(activeDuty),
		.pwmLevel(pwmLevel),
		.pulseIdx(pulseIdx),
		.periodEnd(periodEnd)
	);

	// pin stays on its port level until software hands it to the pwm
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pinQ <= 1'b0;
		end else begin
			pinQ <= portModeSelectOne ? pwmLevel : portLevel;
		end
	end

	assign sharedPwmOutputPin = pinQ;

	// helpers read only by the checks below
	logic everCtrl;
	logic everUpper;
	logic [15:0] cycCnt;
	logic seenEnd;
	logic [1:0] endsSeen;
	logic periodEndQ;
	logic [15:0] highCnt;
	pdp_pkg::pdp_duty_t dutyQ;
	logic selQ;
	logic [16:0] expUnits;
	logic [16:0] expHigh;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			everCtrl <= 1'b0;
			everUpper <= 1'b0;
			cycCnt <= '0;
			seenEnd <= 1'b0;
			endsSeen <= '0;
			periodEndQ <= 1'b0;
			highCnt <= '0;
			dutyQ <= '0;
			selQ <= 1'b0;
		end else begin
			everCtrl <= everCtrl || ctrlWr;
			everUpper <= everUpper || upperWr;
			cycCnt <= periodEnd ? 16'h0000 : cycCnt + 16'h0001;
			seenEnd <= seenEnd || periodEnd;
			if (periodEnd && endsSeen != 2'h2) begin
				endsSeen <= endsSeen + 2'h1;
			end
			periodEndQ <= periodEnd;
			highCnt <= periodEndQ ? 16'h0000 : highCnt + 16'(pwmLevel);
			dutyQ <= activeDuty;
			selQ <= selActive;
		end
	end

	assign expUnits = (17'(dutyQ) + 17'(PULSE_COUNT) > 17'(PERIOD_SHORT)) ?
		17'(PERIOD_SHORT) : 17'(dutyQ) + 17'(PULSE_COUNT);
	assign expHigh = selQ ? {expUnits[15:0], 1'b0} : expUnits;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	property p_period_len;
		periodEnd && seenEnd |->
			cycCnt == (selActive ? 16'(PERIOD_LONG - 1) : 16'(PERIOD_SHORT - 1));
	endproperty
	a_period_len: assert property (p_period_len) else $error("period length wrong");

	property p_tick;
		selActive && unitTick && !periodEnd |=> !unitTick ##1 unitTick;
	endproperty
	a_tick: assert property (p_tick) else $error("slow input clock spacing wrong");

	property p_tick_fast;
		!selActive |-> unitTick;
	endproperty
	a_tick_fast: assert property (p_tick_fast) else $error("fast tick missing");

	property p_ctrl_read;
		wb_ack_o && !wb_we_i && hitCtrl |-> wb_dat_o == {24'h000000, `PDP_WO_READ};
	endproperty
	a_ctrl_read: assert property (p_ctrl_read) else $error("control read not all ones");

	property p_data_read;
		wb_ack_o && !wb_we_i && (hitUpper || hitLower) |-> wb_dat_o[7:0] == `PDP_WO_READ;
	endproperty
	a_data_read: assert property (p_data_read) else $error("duty read not all ones");

	property p_reset_sel;
		!everCtrl |-> !selReg && !selActive;
	endproperty
	a_reset_sel: assert property (p_reset_sel) else $error("reset select not short");

	property p_reset_duty;
		!everUpper |-> activeDuty == '0 && !pendingValid;
	endproperty
	a_reset_duty: assert property (p_reset_duty) else $error("reset duty not zero");

	property p_pair;
		upperWr |=> pendingValid == !$past(periodEnd) &&
			pendingDuty == {$past(wb_dat_i[`PDP_UPPER_MSB:0]), $past(lowerReg)};
	endproperty
	a_pair: assert property (p_pair) else $error("upper and lower bytes paired wrong");

	property p_sync;
		periodEnd && pendingValid && !upperWr |=>
			activeDuty == $past(pendingDuty) && !pendingValid;
	endproperty
	a_sync: assert property (p_sync) else $error("pending duty not applied");

	property p_hold;
		!periodEnd |=> $stable(activeDuty) && $stable(selActive);
	endproperty
	a_hold: assert property (p_hold) else $error("duty changed mid period");

	property p_high_total;
		periodEndQ && endsSeen == 2'h2 |-> 17'(highCnt) + 17'(pwmLevel) == expHigh;
	endproperty
	a_high_total: assert property (p_high_total) else $error("high total wrong");

	c_long_period: cover property (periodEnd && selActive && seenEnd);
	c_upper_load: cover property (periodEnd && pendingValid);
	c_status_read: cover property (wb_ack_o && !wb_we_i && hitStatus);
	c_pin_high: cover property (sharedPwmOutputPin && portModeSelectOne);
endmodule

// ### core/pdp_map.svh
// register indices, reset values, field positions and counts of the pulse-division pwm
`ifndef PDP_MAP_SVH
`define PDP_MAP_SVH

`define PDP_IDX_W 16
`define PDP_IDX_CTRL 16'hFFD0
`define PDP_IDX_UPPER 16'hFFD1
`define PDP_IDX_LOWER 16'hFFD2
`define PDP_IDX_STATUS 16'hFFD3
`define PDP_IDX_PORTMODE 16'hFFD4

`define PDP_CTRL_RESET 8'hFE
`define PDP_UPPER_RESET 8'hC0
`define PDP_LOWER_RESET 8'h00
`define PDP_WO_READ 8'hFF
`define PDP_ZERO_READ 8'h00

`define PDP_SEL_BIT 0
`define PDP_PORTMODE_BIT 0
`define PDP_UPPER_MSB 5
`define PDP_STATUS_LEVEL_BIT 7
`define PDP_STATUS_PEND_BIT 6

`define PDP_PULSES 64
`define PDP_UNIT_STEPS 256
`define PDP_PERIOD_SHORT 16384
`define PDP_ADDR_W 18

`endif

// ### core/pdp_pkg.sv
// shared types of the pulse-division pwm
package pdp_pkg;
	typedef logic [13:0] pdp_duty_t;
	typedef logic [5:0] pdp_pulse_t;
	typedef logic [7:0] pdp_unit_t;
	typedef logic [7:0] pdp_byte_t;
endpackage

// ### core/pdp_pulse_gen.sv
// waveform generator: 64 sub-pulses per period, extra half-steps spread by bit reversal
`timescale 1ns/1ps
`include "pdp_map.svh"

module pdp_pulse_gen #(
	parameter int PULSE_COUNT = `PDP_PULSES,
	parameter int UNIT_STEPS = `PDP_UNIT_STEPS
) (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic unitTick,
	input wire pdp_pkg::pdp_duty_t duty,
	output logic pwmLevel,
	output pdp_pkg::pdp_pulse_t pulseIdx,
	output logic periodEnd
);
	localparam pdp_pkg::pdp_unit_t UNIT_LAST = 8'(UNIT_STEPS - 1);
	localparam pdp_pkg::pdp_pulse_t PULSE_LAST = 6'(PULSE_COUNT - 1);

	if (PULSE_COUNT != `PDP_PULSES || UNIT_STEPS != `PDP_UNIT_STEPS) begin : g_bad
		$error("pulse generator geometry must match the 14-bit duty layout");
	end

	pdp_pkg::pdp_unit_t unitCnt;
	pdp_pkg::pdp_pulse_t revIdx;
	logic extra;
	logic pulseEnd;
	logic [8:0] highWidth;
	logic [6:0] extCnt;

	// bit-reversed index scatters the extended pulses evenly over the period
	for (genvar i = 0; i < 6; i++) begin : g_rev
		assign revIdx[i] = pulseIdx[5 - i];
	end

	assign extra = revIdx < duty[5:0];
	// base width is one half-step plus duty/64; with the extra steps that gives (duty+64) summed over 64 pulses
	assign highWidth = 9'(duty[13:6]) + 9'h001 + 9'(extra);
	assign pulseEnd = unitTick && (unitCnt == UNIT_LAST);
	assign periodEnd = pulseEnd && (pulseIdx == PULSE_LAST);

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			unitCnt <= '0;
			pulseIdx <= '0;
			pwmLevel <= 1'b0;
		end else begin
			unitCnt <= unitCnt + 8'(unitTick);
			pulseIdx <= pulseIdx + 6'(pulseEnd);
			// width 257 saturates to an always-high pulse
			pwmLevel <= 9'(unitCnt) < highWidth;
		end
	end

	// helper: extended pulses seen in the running period
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			extCnt <= '0;
		end else if (periodEnd) begin
			extCnt <= '0;
		end else if (pulseEnd && extra) begin
			extCnt <= extCnt + 7'h01;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	property p_pulse_step;
		pulseEnd |=> unitCnt == '0 && pulseIdx == $past(pulseIdx) + 6'h01;
	endproperty
	a_pulse_step: assert property (p_pulse_step) else $error("sub-pulse index did not advance");

	property p_spread;
		periodEnd |-> extCnt + 7'(extra) == 7'(duty[5:0]);
	endproperty
	a_spread: assert property (p_spread) else $error("extended pulse count wrong");

	c_extra_period: cover property (periodEnd && duty[5:0] != '0);
endmodule

// ### verif/pdp_lpf.sv
// integrate-and-dump filter model hanging on the shared pwm pin
`timescale 1ns/1ps

module pdp_lpf (
	input wire logic sys_clk,
	input wire logic pinLevel,
	input wire logic dump,
	output int area,
	output int runMin,
	output int runMax
);
	int run;
	logic skip;

	// a high run already going at dump time is partial, so it is not measured
	always @(posedge sys_clk) begin
		if (dump) begin
			area = 0;
			run = 0;
			skip = pinLevel;
			runMin = 1 << 20;
			runMax = 0;
		end else if (pinLevel === 1'b1) begin
			area++;
			run++;
		end else begin
			if (run > 0 && !skip) begin
				runMin = (run < runMin) ? run : runMin;
				runMax = (run > runMax) ? run : runMax;
			end
			run = 0;
			skip = 1'b0;
		end
	end
endmodule

// ### verif/pdp_pwm_tb.sv
// self-checking bench of the pulse-division pwm
`timescale 1ns/1ps
`include "pdp_map.svh"

module pdp_pwm_tb;
	localparam logic [17:0] aCtrl = {`PDP_IDX_CTRL, 2'b00};
	localparam logic [17:0] aUpper = {`PDP_IDX_UPPER, 2'b00};
	localparam logic [17:0] aLower = {`PDP_IDX_LOWER, 2'b00};
	localparam logic [17:0] aPort = {`PDP_IDX_PORTMODE, 2'b00};
	localparam logic [17:0] aStat = {`PDP_IDX_STATUS, 2'b00};
	localparam logic [17:0] aNone = {16'hFFE0, 2'b00};
	logic sysClk = 1'b0;
	logic resetN, wbCyc, wbStb, wbWe, wbAck, portLevel, pin, dump, lv;
	logic [17:0] wbAdr;
	logic [3:0] wbSel;
	logic [31:0] wbDatI, wbDatO, rd;
	int errTotal = 0;
	int testsRun = 0;
	int cycles = 0;
	int area, runMin, runMax, lowHeld;
	int dutyQ[$];

	initial forever #5 sysClk = ~sysClk;

	pdp_pwm i_pdp_pwm (.sys_clk(sysClk), .reset_n(resetN), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
		.wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
		.wb_dat_o(wbDatO), .wb_ack_o(wbAck), .portLevel(portLevel), .sharedPwmOutputPin(pin));
	pdp_lpf i_pdp_lpf (.sys_clk(sysClk), .pinLevel(pin), .dump(dump), .area(area),
		.runMin(runMin), .runMax(runMax));

	always @(posedge sysClk) portLevel <= 1'($urandom());

	always @(posedge sysClk) begin
		cycles++;
		if (cycles == 100000) begin
			errTotal++;
			print_verdict();
		end
	end

	task print_verdict;
		$display("checks %0d errors %0d", testsRun, errTotal);
		if (errTotal == 0 && testsRun > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	task chkReg(input string what, input logic [31:0] exp, input logic [31:0] got);
		testsRun++;
		if (got !== exp) begin
			errTotal++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task chkNum(input string what, input int exp, input int got);
		testsRun++;
		if (got != exp) begin
			errTotal++;
			$display("MISMATCH %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// the model keeps the held low byte and queues each full duty taken by an upper write
	task automatic wb(input logic we, input logic [17:0] adr, input logic [7:0] d);
		@(posedge sysClk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= adr;
		wbSel <= {3'($urandom()), 1'b1};
		wbDatI <= {24'($urandom()), d};
		@(posedge sysClk);
		while (wbAck !== 1'b1) @(posedge sysClk);
		rd = wbDatO;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		if (we && adr == aLower) lowHeld = d;
		if (we && adr == aUpper) dutyQ.push_back({d[5:0], lowHeld[7:0]});
	endtask

	task automatic loadDuty();
		int d;
		d = $urandom_range(16255);
		wb(1'b1, aLower, 8'($urandom()));
		wb(1'b1, aLower, d[7:0]);
		wb(1'b1, aUpper, {2'($urandom()), d[13:8]});
		wb(1'b0, aUpper, 8'h00);
		chkReg("upper read", 32'h000000FF, rd);
	endtask

	// poll the pending flag: returns just after the boundary that took the new duty
	task automatic waitApplied();
		rd = 32'h00000040;
		while (rd[`PDP_STATUS_PEND_BIT]) wb(1'b0, aStat, 8'h00);
	endtask

	// one full period of samples: total high time and narrowest and widest sub-pulse
	task automatic measure(input int n, input int hs);
		int d;
		int a;
		d = dutyQ.size() ? dutyQ[$] : 0;
		@(posedge sysClk);
		dump <= 1'b1;
		@(posedge sysClk);
		dump <= 1'b0;
		repeat (n) @(posedge sysClk);
		@(negedge sysClk);
		a = area;
		// one sub-pulse more, so no pulse index is lost to a cut run at either end
		repeat (n / 64) @(posedge sysClk);
		@(negedge sysClk);
		chkNum("high total", (d + 64) * hs, a);
		chkNum("narrow run", (1 + d / 64) * hs, runMin);
		chkNum("wide run", (1 + d / 64 + ((d % 64) != 0)) * hs, runMax);
	endtask

	initial begin
		void'($urandom(32'h1AC7));
		resetN = 1'b0;
		wbCyc = 1'b0;
		wbStb = 1'b0;
		wbWe = 1'b0;
		wbAdr = '0;
		wbSel = '0;
		wbDatI = '0;
		dump = 1'b0;
		lowHeld = 0;
		repeat (10) @(posedge sysClk);
		resetN <= 1'b1;
		repeat (8) begin
			@(posedge sysClk);
			lv = portLevel;
			@(posedge sysClk);
			chkReg("pin as port", {31'h0, lv}, {31'h0, pin});
		end
		for (int i = 0; i < 3; i++) begin
			wb(1'b0, aCtrl + 18'(4 * i), 8'h00);
			chkReg("write-only read", 32'h000000FF, rd);
		end
		wb(1'b1, aNone, 8'($urandom()));
		wb(1'b0, aNone, 8'h00);
		chkReg("unmapped read", 32'h00000000, rd);
		wb(1'b1, aPort, 8'h01);
		wb(1'b0, aPort, 8'h00);
		chkReg("port mode", 32'h00000001, rd);
		measure(16384, 1);
		loadDuty();
		waitApplied();
		measure(16384, 1);
		wb(1'b1, aCtrl, 8'hFF);
		wb(1'b0, aCtrl, 8'h00);
		chkReg("select read", 32'h000000FF, rd);
		loadDuty();
		waitApplied();
		measure(32768, 2);
		print_verdict();
	end
endmodule
